/* File: common/php_pkg.sv */
package php_pkg;
  // strap codes for bus style
  localparam logic [1:0] STYLE_SEP = 2'h0;  // separate read and write strobes
  localparam logic [1:0] STYLE_DS = 2'h1;   // data strobe plus direction
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  // number of latched status registers and their byte addresses
  localparam int NUM_STAT = 2;
  localparam logic [7:0] STAT0_ADDR = 8'h00;
  localparam logic [7:0] STAT1_ADDR = 8'h01;
  localparam logic [7:0] MASK0_ADDR = 8'h02;
  localparam logic [7:0] MASK1_ADDR = 8'h03;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // host cycle pacing, in system clocks
  localparam int SETUP_CYC = 4;
  localparam int STROBE_CYC = 6;
  // host state machine
  typedef enum logic [1:0] {
    PHP_IDLE = 2'b00,
    PHP_SETUP = 2'b01,
    PHP_STROBE = 2'b10,
    PHP_HOLD = 2'b11
  } php_hstate_t;
endpackage

/* File: common/php_if.sv */
interface php_if;
  // host-driven lines
  logic [7:0] addr;
  logic cs_n;
  logic rd_n;       // read strobe, or direction in data-strobe style
  logic wr_n;       // write strobe, or transfer_strobe_n in data-strobe style
  logic [7:0] hdata_o;
  logic hdata_oe;
  // device-driven lines
  logic [7:0] ddata_o;
  logic ddata_oe;
  logic int_n_o;
  logic int_n_oe;
  logic [7:0] data;
  logic int_n;
  // resolved wire levels, int pulled up when nobody drives it
  // undriven data floats high, so a silent device cannot pass for a zero read
  assign data = ddata_oe ? ddata_o : (hdata_oe ? hdata_o : 8'hff);
  assign int_n = int_n_oe ? int_n_o : 1'b1;
  modport device (input addr, cs_n, rd_n, wr_n, data,
                  output ddata_o, ddata_oe, int_n_o, int_n_oe);
  modport host (output addr, cs_n, rd_n, wr_n, hdata_o, hdata_oe,
                input data, int_n);
endinterface

/* File: hdl/php_device.sv */
// Operation
// - eight-bit data, style chosen by straps
// - straps 00 use separate read/write strobes
// - straps 01 use strobe plus direction
// - eight plain address lines select registers
// - no multiplexed address and data
// - strobes ignored while chip select high
// - low pulse on strobe performs cycle
// - separate strobes mark type and time
// - direction high reads, low writes
// - data strobe alone times the transfer
// - open-drain interrupt pulls low when unmasked
// - reading latched status clears it
// - events during read survive clear
// - host services all bits per read
// - port is twenty signals in total
// - interrupt floats until enabled source active
// - bus outputs float while reset held
module php_device #(
  parameter int NSTAT = php_pkg::NUM_STAT
) (
  input wire logic clock,
  input wire logic rst,
  php_if.device bus,
  input wire logic [1:0] bus_style_strap,
  input wire logic hostless_strap,
  input wire logic [NSTAT*8-1:0] status_event,
  output logic port_enabled,
  output logic [1:0] active_style
);
  // three-stage samplers for host pins: addr, cs, rd, wr, data
  localparam int SW = 8 + 1 + 1 + 1 + 8;
  logic [SW-1:0] s1_r, s2_r, s3_r, s1_nxt;
  logic [SW-1:0] flt_r, flt_nxt; // agreed pin levels, what the port logic sees
  logic [7:0] a_s, d_s;
  logic cs_s, rd_s, wr_s;
  // strap capture
  logic [1:0] style_r, style_nxt;
  logic hless_r, hless_nxt, cap_r, cap_nxt;
  // strobe history and decoded pulses
  logic strb_prev_r, strb_prev_nxt;
  logic strb_now, dir_read, start, finish;
  logic rd_active;
  // registers
  logic [7:0] stat_r [NSTAT];
  logic [7:0] stat_nxt [NSTAT];
  logic [7:0] mask_r [NSTAT];
  logic [7:0] mask_nxt [NSTAT];
  logic [7:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic irq_r, irq_nxt;
  logic [NSTAT-1:0] clr_hit;
  logic ready;

  // sampled value counts once stages two and three agree
  always_comb begin
    s1_nxt = {bus.addr, bus.cs_n, bus.rd_n, bus.wr_n, bus.data};
    // per bit: take the new level only where stages two and three agree
    flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
  end
  // a one-cycle glitch on a pin never reaches the decoder, at four clocks of latency
  assign {a_s, cs_s, rd_s, wr_s, d_s} = flt_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      flt_r <= '1; // idle levels: deselected, strobes high
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt; // holds its old bit until two samples agree
    end
  end

  // straps caught once after reset release
  always_comb begin
    style_nxt = style_r;
    hless_nxt = hless_r;
    cap_nxt = 1'b1;
    if (!cap_r) begin
      style_nxt = bus_style_strap;
      hless_nxt = hostless_strap;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      style_r <= php_pkg::STYLE_SEP;
      hless_r <= 1'b1;
      cap_r <= 1'b0;
    end else begin
      style_r <= style_nxt;
      hless_r <= hless_nxt;
      cap_r <= cap_nxt;
    end
  end

  // port only live in the two host styles with hostless strap low
  assign ready = cap_r && !hless_r &&
                 (style_r == php_pkg::STYLE_SEP || style_r == php_pkg::STYLE_DS);
  assign port_enabled = ready;
  assign active_style = style_r;

  // combined strobe: either strobe in separate style, data strobe otherwise
  always_comb begin
    if (style_r == php_pkg::STYLE_SEP) begin
      strb_now = ready && !cs_s && (!rd_s || !wr_s);
      dir_read = !rd_s;
    end else begin
      strb_now = ready && !cs_s && !wr_s;
      dir_read = rd_s;
    end
  end
  // chip select high masks strobes entirely
  assign start = strb_now && !strb_prev_r;
  assign finish = !strb_now && strb_prev_r;
  assign rd_active = strb_prev_r && doe_r;

  always_comb begin
    strb_prev_nxt = strb_now;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strb_prev_r <= 1'b0;
    end else begin
      strb_prev_r <= strb_prev_nxt;
    end
  end

  // register file: latched status and masks, addressed directly
  always_comb begin
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    clr_hit = '0;
    for (int i = 0; i < NSTAT; i++) begin
      mask_nxt[i] = mask_r[i];
    end
    if (start && dir_read) begin
      doe_nxt = 1'b1;
      if (a_s == php_pkg::STAT0_ADDR) begin
        dout_nxt = stat_r[0];
      end else if (a_s == php_pkg::STAT1_ADDR) begin
        dout_nxt = stat_r[1];
      end else if (a_s == php_pkg::MASK0_ADDR) begin
        dout_nxt = mask_r[0];
      end else if (a_s == php_pkg::MASK1_ADDR) begin
        dout_nxt = mask_r[1];
      end else begin
        dout_nxt = php_pkg::DATA_ZERO; // unmapped reads as zero
      end
    end
    if (finish) begin
      doe_nxt = 1'b0;
      // read ends: clear the status register that was read
      if (rd_active && a_s == php_pkg::STAT0_ADDR) begin
        clr_hit[0] = 1'b1;
      end else if (rd_active && a_s == php_pkg::STAT1_ADDR) begin
        clr_hit[1] = 1'b1;
      end
      // write data taken at the trailing strobe edge
      if (!doe_r && a_s == php_pkg::MASK0_ADDR) begin
        mask_nxt[0] = d_s;
      end else if (!doe_r && a_s == php_pkg::MASK1_ADDR) begin
        mask_nxt[1] = d_s;
      end
    end
  end

  // status latches; events set even on the clearing cycle
  always_comb begin
    for (int i = 0; i < NSTAT; i++) begin
      // clears only bits the host saw, new events win
      stat_nxt[i] = (clr_hit[i] ? (stat_r[i] & ~dout_r) : stat_r[i])
                    | status_event[i*8 +: 8];
    end
  end

  // interrupt level from masked latched status
  always_comb begin
    irq_nxt = 1'b0;
    for (int i = 0; i < NSTAT; i++) begin
      irq_nxt = irq_nxt | (|(stat_r[i] & mask_r[i]));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSTAT; i++) begin
        stat_r[i] <= php_pkg::DATA_ZERO;
        mask_r[i] <= php_pkg::MASK_RST;
      end
      dout_r <= php_pkg::DATA_ZERO;
      doe_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      for (int i = 0; i < NSTAT; i++) begin
        stat_r[i] <= stat_nxt[i];
        mask_r[i] <= mask_nxt[i];
      end
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      irq_r <= irq_nxt;
    end
  end

  // outputs float in reset; data floats outside reads, interrupt while no unmasked status bit is set
  assign bus.ddata_o = dout_r;
  assign bus.ddata_oe = doe_r && !rst;
  assign bus.int_n_o = 1'b0; // open drain only pulls low
  assign bus.int_n_oe = irq_r && !rst;
endmodule

/* File: hdl/php_host.sv */
module php_host (
  input wire logic clock,
  input wire logic rst,
  php_if.host bus,
  input wire logic [1:0] style,
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic irq
);
  php_pkg::php_hstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt, done_r, done_nxt;
  logic [7:0] a_r, a_nxt, w_r, w_nxt, rd_r, rd_nxt;

  // sequencer: address, strobe low, data sampled at strobe end
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    a_nxt = a_r;
    w_nxt = w_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      php_pkg::PHP_IDLE: begin
        if (req) begin
          st_nxt = php_pkg::PHP_SETUP;
          wr_nxt = req_write;
          a_nxt = req_addr;
          w_nxt = req_wdata;
          cnt_nxt = 4'(php_pkg::SETUP_CYC);
        end
      end
      php_pkg::PHP_SETUP: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = php_pkg::PHP_STROBE;
          cnt_nxt = 4'(php_pkg::STROBE_CYC);
        end
      end
      php_pkg::PHP_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = php_pkg::PHP_HOLD;
          rd_nxt = wr_r ? rd_r : bus.data;
          cnt_nxt = 4'(php_pkg::SETUP_CYC);
        end
      end
      default: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = php_pkg::PHP_IDLE;
          done_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= php_pkg::PHP_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      a_r <= 8'h00;
      w_r <= 8'h00;
      rd_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      a_r <= a_nxt;
      w_r <= w_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  // pin drive per style; chip select low across the whole cycle
  logic strobe;
  assign strobe = (st_r == php_pkg::PHP_STROBE);
  assign bus.addr = a_r;
  assign bus.cs_n = (st_r == php_pkg::PHP_IDLE);
  assign bus.rd_n = (style == php_pkg::STYLE_SEP) ? !(strobe && !wr_r) : !wr_r;
  assign bus.wr_n = (style == php_pkg::STYLE_SEP) ? !(strobe && wr_r) : !strobe;
  assign bus.hdata_o = w_r;
  assign bus.hdata_oe = wr_r && (st_r != php_pkg::PHP_IDLE);
  assign busy = (st_r != php_pkg::PHP_IDLE);
  assign done = done_r;
  assign rdata = rd_r; // one read returns all bits
  assign irq = !bus.int_n;
endmodule

/* File: sim/php_checker.sv */
module php_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic hdata_oe,
  input wire logic ddata_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  // one clock domain, reset clears all history
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // strobe kept low for the minimum span
  sequence s_held_low(s);
    (!s) [*4];
  endsequence
  // a device drive that began only after select had settled
  sequence s_sel_settled;
    !cs_n && !$past(cs_n, 3);
  endsequence
  property p_float_rst;
    $fell(rst) |-> !ddata_oe && !int_n_oe;
  endproperty
  a_float_rst: assert property (p_float_rst) else $error("bus driven out of reset");
  property p_cs_quiet;
    cs_n [*6] |-> !ddata_oe;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("drive while deselected");
  property p_no_fight;
    !(ddata_oe && hdata_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_drain_only;
    int_n_oe |-> !int_n_o;
  endproperty
  a_drain_only: assert property (p_drain_only) else $error("interrupt driven high");
  property p_drive_cause;
    $rose(ddata_oe) |-> s_sel_settled;
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("drive without select");
  property p_wr_width;
    $fell(wr_n) && !cs_n |-> s_held_low(wr_n);
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("strobe too short");
  property p_addr_hold;
    !cs_n && !$past(cs_n) |-> $stable(addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  property p_drive_ends;
    ddata_oe |-> ##[1:24] !ddata_oe;
  endproperty
  a_drive_ends: assert property (p_drive_ends) else $error("data drive never ends");
  property p_host_drive;
    hdata_oe |-> !cs_n;
  endproperty
  a_host_drive: assert property (p_host_drive) else $error("host drives unselected");
endmodule

/* File: sim/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // one row per ordinary transfer
  typedef struct {logic [1:0] sty; logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] x;} php_row_t;
  localparam logic [7:0] M0 = php_pkg::MASK0_ADDR;
  localparam logic [7:0] S0 = php_pkg::STAT0_ADDR;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hw = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] straps = 2'h0;
  logic [1:0] style = 2'h0;
  logic [1:0] act;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] r1;
  logic [15:0] ev = 16'h0000;
  logic busy, done, irq, en;
  int err_count = 0;
  int cmp_count = 0;
  // writes to status are dropped, unmapped reads give zero
  php_row_t rows[10] = '{
    '{2'h0, 1'b1, M0, 8'h5a, 8'h00}, '{2'h0, 1'b0, M0, 8'h00, 8'h5a},
    '{2'h0, 1'b1, php_pkg::MASK1_ADDR, 8'ha5, 8'h00},
    '{2'h0, 1'b0, php_pkg::MASK1_ADDR, 8'h00, 8'ha5},
    '{2'h0, 1'b1, S0, 8'hff, 8'h00}, '{2'h0, 1'b0, S0, 8'h00, 8'h00},
    '{2'h0, 1'b0, 8'h10, 8'h00, 8'h00}, '{2'h1, 1'b1, M0, 8'hc3, 8'h00},
    '{2'h1, 1'b0, M0, 8'h00, 8'hc3}, '{2'h1, 1'b0, 8'hff, 8'h00, 8'h00}};
  always #2.5 clock = ~clock;
  php_if bus();
  php_device u_php_device (.clock(clock), .rst(rst), .bus(bus), .bus_style_strap(straps),
    .hostless_strap(hw), .status_event(ev), .port_enabled(en), .active_style(act));
  php_host u_php_host (.clock(clock), .rst(rst), .bus(bus), .style(style), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata), .irq(irq));
  php_checker u_php_checker (.clock(clock), .rst(rst), .addr(bus.addr), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .hdata_oe(bus.hdata_oe), .ddata_oe(bus.ddata_oe),
    .int_n_o(bus.int_n_o), .int_n_oe(bus.int_n_oe));
  // verdict and end of run, also used when a wait runs dry
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // straps settle during reset, captured on release
  task do_reset(input logic [1:0] s, input logic h);
    @(negedge clock);
    rst = 1'b1;
    straps = s;
    style = s;
    hw = h;
    repeat (16) @(negedge clock);
    chk1("bus float", 1'b0, bus.ddata_oe | bus.int_n_oe);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    chk1("enabled", !h && !s[1], en);
    chk8("style", {6'h00, s}, {6'h00, act});
  endtask
  // one host transfer, bounded wait on done
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge clock);
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req = 1'b0;
    chk1("busy", 1'b1, busy);
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    if (n >= 60) begin
      err_count++;
      $display("wrong value done expected 1 seen 0");
      report_and_stop;
    end
    chk1("busy", 1'b0, busy);
  endtask
  // single-cycle status event pulse
  task pulse(input logic [15:0] v);
    @(negedge clock);
    ev = v;
    @(negedge clock);
    ev = 16'h0000;
  endtask
  initial begin
    foreach (rows[i]) begin
      if (i == 0 || rows[i].sty !== rows[i-1].sty) do_reset(rows[i].sty, 1'b0);
      xfer(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk8("row read", rows[i].x, rdata);
    end
    $display("test rows done");
    // masked event must not pull the line
    xfer(1'b1, M0, 8'h00);
    pulse(16'h0080);
    repeat (6) @(negedge clock);
    chk1("irq masked", 1'b0, irq);
    xfer(1'b1, M0, 8'h81);
    repeat (6) @(negedge clock);
    chk1("irq on", 1'b1, irq);
    // event lands as the read clears, must survive the clear
    fork
      xfer(1'b0, S0, 8'h00);
      begin
        // event sampled on the very edge that applies the read clear
        repeat (15) @(negedge clock);
        pulse(16'h0001);
      end
    join
    r1 = rdata;
    chk8("stat first", 8'h80, r1);
    xfer(1'b0, S0, 8'h00);
    chk8("stat kept", 8'h01, rdata);
    chk8("stat cleared", 8'h00, rdata & 8'h80);
    xfer(1'b0, S0, 8'h00);
    chk8("stat empty", 8'h00, rdata);
    repeat (6) @(negedge clock);
    chk1("irq off", 1'b0, irq);
    $display("test status done");
    // refused strap settings leave the port dead
    do_reset(2'h2, 1'b0);
    do_reset(2'h0, 1'b1);
    xfer(1'b0, M0, 8'h00);
    chk8("hostless read", 8'hff, rdata);
    $display("test straps done");
    report_and_stop;
  end
endmodule
